// file: fes_host.sv
`default_nettype none
module fes_host
  import fes_pkg::*;
#(
  parameter int AW = 19 // word address width
) (
  // ************** clock and reset **************
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  input  wire logic          ce_i,
  // ************** user command port **************
  input  wire logic          cmd_valid_i,
  input  wire fes_op_t       cmd_op_i,
  input  wire logic [AW-1:0] cmd_addr_i,
  output logic               cmd_ready_o,
  output logic               done_o,
  output logic [7:0]         status_o,
  output logic               busy_o,
  output logic               fail_o,
  // ************** flash pins **************
  output logic [AW-1:0]      fl_addr_o,
  input  wire logic [7:0]    fl_dq_i,
  output logic [7:0]         fl_dq_o,
  output logic               fl_dq_oe_o,
  output logic               fl_ce_n_o,
  output logic               fl_oe_n_o,
  output logic               fl_we_n_o,
  input  wire logic          ready_busy_out_i
);
  // ************************************************
  // pin synchronisers
  // ************************************************
  logic [7:0] dq_meta;  // first stage, read only by dq_sync
  logic [7:0] dq_sync;  // data safe to use
  logic       rb_meta;  // first stage
  logic       rb_sync;  // ready/busy, high when ready
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      dq_meta <= 8'h00;
      dq_sync <= 8'h00;
      rb_meta <= 1'b1;
      rb_sync <= 1'b1;
    end
    else if (ce_i)
    begin
      dq_meta <= fl_dq_i;
      dq_sync <= dq_meta;
      rb_meta <= ready_busy_out_i;
      rb_sync <= rb_meta;
    end
  end

  // ************************************************
  // sequencer
  // ************************************************
  typedef enum logic [2:0] {
    FES_IDLE, FES_WR_SET, FES_WR_PULSE, FES_WR_HOLD, FES_RD_SET, FES_RD_WAIT, FES_DONE
  } fes_state_t;
  fes_state_t state;        // bus cycle state
  logic [2:0] wr_idx;       // current write of the sequence
  logic [2:0] wr_last;      // last write index of sequence
  logic [7:0] phase;        // phase counter
  fes_op_t    op;           // latched command
  logic [AW-1:0] blk_addr;  // target block address
  logic [7:0] prev_status;  // previous status read for toggle compare
  logic       have_prev;    // a previous status read exists

  // address/data of write number idx for the current op
  function automatic logic [AW+7:0] seq_word(input logic [2:0] idx, input fes_op_t o,
                                             input logic [AW-1:0] ba);
    logic [AW-1:0] a;
    logic [7:0]    d;
    a = '0;
    d = FES_DAT_RESET;
    unique case (o)
      FES_OP_CHIP, FES_OP_BLOCK: // six-write erase sequence
      begin
        a[10:0] = (idx == 3'd1 || idx == 3'd4) ? FES_ADDR_UNLOCK2 : FES_ADDR_UNLOCK1;
        d = (idx == 3'd1 || idx == 3'd4) ? FES_DAT_55 : FES_DAT_AA;
        if (idx == 3'd2)
          d = FES_DAT_SETUP;
        if (idx == 3'd5 && o == FES_OP_CHIP)
          d = FES_DAT_CHIP;
        if (idx == 3'd5 && o == FES_OP_BLOCK)
        begin
          a = ba;
          d = FES_DAT_BLOCK;
        end
      end
      FES_OP_ADD:                  // only sixth write repeated
      begin
        a = ba;
        d = FES_DAT_BLOCK;
      end
      FES_OP_SUSPEND: d = FES_DAT_SUSPEND;
      FES_OP_RESUME:  d = FES_DAT_BLOCK;
      FES_OP_RESET:   d = FES_DAT_RESET;
      FES_OP_STATUS:  d = FES_DAT_RESET;   // unused, read only
    endcase
    return {a, d};
  endfunction

  logic [AW+7:0] word_now; // address and data for this write
  assign word_now = seq_word(wr_idx, op, blk_addr);

  // main state machine: one bus write or read per command step
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state       <= FES_IDLE;
      wr_idx      <= 3'd0;
      wr_last     <= 3'd0;
      phase       <= 8'h00;
      op          <= FES_OP_STATUS;
      blk_addr    <= '0;
      cmd_ready_o <= 1'b1;
      done_o      <= 1'b0;
      fl_addr_o   <= '0;
      fl_dq_o     <= 8'h00;
      fl_dq_oe_o  <= 1'b0;
      fl_ce_n_o   <= 1'b1;
      fl_oe_n_o   <= 1'b1;
      fl_we_n_o   <= 1'b1;
    end
    else if (ce_i)
    begin
      done_o <= 1'b0;
      unique case (state)
        FES_IDLE:
        begin
          if (cmd_valid_i)
          begin
            op          <= cmd_op_i;
            blk_addr    <= cmd_addr_i;
            wr_idx      <= 3'd0;
            wr_last     <= (cmd_op_i == FES_OP_CHIP || cmd_op_i == FES_OP_BLOCK) ? 3'd5 : 3'd0;
            cmd_ready_o <= 1'b0;
            phase       <= 8'h00;
            // status polls are reads; host polls before next command
            state       <= (cmd_op_i == FES_OP_STATUS) ? FES_RD_SET : FES_WR_SET;
          end
        end
        FES_WR_SET: // present address and data, chip enabled
        begin
          fl_addr_o  <= word_now[AW+7:8];
          fl_dq_o    <= word_now[7:0];
          fl_dq_oe_o <= 1'b1;
          fl_ce_n_o  <= 1'b0;
          phase      <= 8'h00;
          state      <= FES_WR_PULSE;
        end
        FES_WR_PULSE: // write strobe low for one phase
        begin
          fl_we_n_o <= 1'b0;
          phase     <= phase + 8'h01;
          if (phase == 8'(FES_PHASE_CYC))
          begin
            fl_we_n_o <= 1'b1;
            phase     <= 8'h00;
            state     <= FES_WR_HOLD;
          end
        end
        FES_WR_HOLD: // data hold and recovery
        begin
          phase <= phase + 8'h01;
          if (phase == 8'(FES_PHASE_CYC))
          begin
            fl_dq_oe_o <= 1'b0;
            fl_ce_n_o  <= 1'b1;
            if (wr_idx == wr_last)
              state <= FES_DONE;
            else
            begin
              wr_idx <= wr_idx + 3'd1;
              state  <= FES_WR_SET;
            end
          end
        end
        FES_RD_SET: // status read at the target address
        begin
          fl_addr_o  <= blk_addr; // alt toggle needs block address
          fl_dq_oe_o <= 1'b0;
          fl_ce_n_o  <= 1'b0;
          fl_oe_n_o  <= 1'b0;
          phase      <= 8'h00;
          state      <= FES_RD_WAIT;
        end
        FES_RD_WAIT: // access time plus two synchroniser stages
        begin
          phase <= phase + 8'h01;
          if (phase == 8'(FES_PHASE_CYC + 2))
          begin
            fl_ce_n_o <= 1'b1;
            fl_oe_n_o <= 1'b1;
            state     <= FES_DONE;
          end
        end
        FES_DONE:
        begin
          done_o      <= 1'b1;
          cmd_ready_o <= 1'b1;
          state       <= FES_IDLE;
        end
      endcase
    end
  end

  // ************************************************
  // status interpretation
  // ************************************************
  // busy while toggle bit inverts between reads; stops when done or suspended
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      status_o    <= 8'h00;
      prev_status <= 8'h00;
      have_prev   <= 1'b0;
      busy_o      <= 1'b0;
      fail_o      <= 1'b0;
    end
    else if (ce_i)
    begin
      if (state == FES_RD_WAIT && phase == 8'(FES_PHASE_CYC + 2))
      begin
        status_o    <= dq_sync;
        prev_status <= dq_sync;
        have_prev   <= 1'b1;
        busy_o      <= have_prev && (dq_sync[FES_BIT_TOGGLE] != prev_status[FES_BIT_TOGGLE]);
        // error counts only while still toggling
        fail_o      <= have_prev && dq_sync[FES_BIT_ERROR]
                       && (dq_sync[FES_BIT_TOGGLE] != prev_status[FES_BIT_TOGGLE]);
      end
      else if (state == FES_WR_SET)
      begin
        have_prev <= 1'b0; // a new write command restarts toggle tracking
        if (op == FES_OP_RESET)
          fail_o <= 1'b0;
      end
    end
  end

  // ************************************************
  // block selection window
  // ************************************************
  logic [11:0] win_cnt;  // cycles since the last block confirm, saturating
  logic        win_open; // a block selection may still be added
  logic        sel_edge; // write strobe rises on a block confirm
  assign sel_edge = state == FES_WR_PULSE && phase == 8'(FES_PHASE_CYC)
                    && (op == FES_OP_ADD || (op == FES_OP_BLOCK && wr_idx == 3'd5));
  // the device starts erasing once this runs out, so a late add would be lost silently
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      win_cnt  <= 12'h000;
      win_open <= 1'b0;
    end
    else if (ce_i)
    begin
      if (sel_edge)
      begin
        win_cnt  <= 12'h000;
        win_open <= 1'b1;
      end
      else if (win_cnt < 12'(FES_WIN_CYC))
        win_cnt <= win_cnt + 12'h001;
      else
        win_open <= 1'b0;   // window closed, erase under way
    end
  end
  AST_ADD_IN_WINDOW: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ce_i && sel_edge && op == FES_OP_ADD) |-> (win_open && win_cnt < 12'(FES_WIN_CYC)))
    else $error("block added after selection window");

  // ************************************************
  // checks
  // ************************************************
  AST_ERASE_SIX_WRITES: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ce_i && state == FES_IDLE && cmd_valid_i && cmd_op_i == FES_OP_CHIP) |=> (wr_last == 3'd5))
    else $error("chip erase not six writes");
  AST_CONFIRM_DATA: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state == FES_WR_SET && wr_idx == 3'd5 && op == FES_OP_BLOCK) |-> (word_now[7:0] == FES_DAT_BLOCK))
    else $error("block confirm data wrong");
  AST_SUSPEND_DATA: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ce_i && state == FES_WR_SET && op == FES_OP_SUSPEND) |=> (fl_dq_o == FES_DAT_SUSPEND && fl_dq_oe_o))
    else $error("suspend data wrong");
  AST_WE_OE_EXCL: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !(~fl_we_n_o && ~fl_oe_n_o))
    else $error("write and read strobes together");
  AST_RESUME_DATA: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ce_i && state == FES_WR_SET && op == FES_OP_RESUME) |=> (fl_dq_o == FES_DAT_BLOCK && fl_dq_oe_o))
    else $error("resume data wrong");
  AST_RESET_DATA: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ce_i && state == FES_WR_SET && op == FES_OP_RESET) |=> (fl_dq_o == FES_DAT_RESET && fl_dq_oe_o))
    else $error("read/reset data wrong");
endmodule // fes_host
`default_nettype wire

// file: fes_pkg.sv
// Notes on behaviour
// - chip erase is six bus writes
// - failure needs read/reset to clear
// - extra blocks repeat only sixth write
// - add blocks within fifty microsecond window
// - resume restarts; suspend any number times
// - erase unlock words and codes
// - suspend B0, resume 30, any address
`default_nettype none
package fes_pkg;
  // ************************************************
  // command addresses and data (word mode)
  // ************************************************
  localparam logic [10:0] FES_ADDR_UNLOCK1 = 11'h555; // first unlock address
  localparam logic [10:0] FES_ADDR_UNLOCK2 = 11'h2aa; // second unlock address
  localparam logic [7:0]  FES_DAT_AA       = 8'haa;   // unlock data one
  localparam logic [7:0]  FES_DAT_55       = 8'h55;   // unlock data two
  localparam logic [7:0]  FES_DAT_SETUP    = 8'h80;   // erase setup
  localparam logic [7:0]  FES_DAT_CHIP     = 8'h10;   // chip erase confirm
  localparam logic [7:0]  FES_DAT_BLOCK    = 8'h30;   // block erase confirm, resume
  localparam logic [7:0]  FES_DAT_SUSPEND  = 8'hb0;   // erase suspend
  localparam logic [7:0]  FES_DAT_RESET    = 8'hf0;   // read/reset
  // ************************************************
  // status word bit positions
  // ************************************************
  localparam int FES_BIT_POLL   = 7; // polling_bit
  localparam int FES_BIT_TOGGLE = 6; // toggle_bit
  localparam int FES_BIT_ERROR  = 5; // error_bit
  localparam int FES_BIT_TIMER  = 3; // erase_timer_bit
  localparam int FES_BIT_ALT    = 2; // alt_toggle_bit
  // ************************************************
  // timing
  // ************************************************
  localparam int FES_CLK_NS     = 20;  // 50 MHz clock period
  localparam int FES_CYC_NS     = 80;  // bus cycle phase, comfortably over 70 ns access
  localparam int FES_PHASE_CYC  = (FES_CYC_NS + FES_CLK_NS - 1) / FES_CLK_NS; // least time, rounded up
  localparam int FES_WIN_US     = 50;  // block selection window
  localparam int FES_WIN_CYC    = (FES_WIN_US * 1000) / FES_CLK_NS; // longest time, rounded down
  localparam int FES_SUSP_US    = 15;  // suspend latency of the device
  localparam int FES_SUSP_CYC   = (FES_SUSP_US * 1000 + FES_CLK_NS - 1) / FES_CLK_NS;
  // ************************************************
  // user commands
  // ************************************************
  typedef enum logic [2:0] {
    FES_OP_CHIP, FES_OP_BLOCK, FES_OP_ADD, FES_OP_SUSPEND,
    FES_OP_RESUME, FES_OP_RESET, FES_OP_STATUS
  } fes_op_t;
endpackage : fes_pkg
`default_nettype wire

// file: fes_flash_model.sv
`default_nettype none
module fes_flash_model
  import fes_pkg::*;
#(
  parameter int          ERASE_US = 40,      // shortened erase time
  parameter logic [15:0] PROT     = 16'h0000 // protected blocks, skipped without error
) (
  // ****** flash pins ******
  input  wire logic [18:0] addr_i,
  input  wire logic [7:0]  dq_i,
  output logic [7:0]       dq_o,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  output logic             rb_o,
  // ****** fault injection ******
  input  wire logic        fail_i
);
  timeunit 1ns;
  timeprecision 1ns;
  typedef enum logic [2:0] {RD, CHIP, WIN, ERS, SUSP, ERR} fes_mode_t;
  fes_mode_t   mode = RD;    // device mode
  logic [2:0]  step = 3'h0;  // unlock progress
  logic [15:0] sel = 16'h0;  // blocks being erased
  logic        tog = 1'b0;   // toggle_bit
  logic        alt = 1'b0;   // alt_toggle_bit
  logic [7:0]  last = 8'h0;  // last value driven
  int          tmr = 0;      // microseconds left
  wire         rd = !ce_n_i && !oe_n_i;
  wire         in_sel = sel[addr_i[18:15]];
  wire         stat = mode != RD && (mode != SUSP || in_sel);
  // polling bit is the complement of the erased one while busy
  wire  [7:0]  word = {mode == SUSP, tog, mode == ERR, 1'b0, mode != WIN, alt, 2'h0};
  wire  [10:0] ua = (step == 3'h1 || step == 3'h4) ? FES_ADDR_UNLOCK2 : FES_ADDR_UNLOCK1;
  wire  [7:0]  ud = step == 3'h2 ? FES_DAT_SETUP : (step == 3'h1 || step == 3'h4) ? FES_DAT_55 : FES_DAT_AA;
  // released bus shows the inverse, so a stale value never passes
  assign dq_o = rd ? (stat ? word : 8'hff) : ~last;
  assign rb_o = !(mode inside {CHIP, WIN, ERS});
  always @(dq_o)
    if (rd)
      last = dq_o;
  // ******
  // command writes, taken as the write strobe rises
  // ******
  always @(posedge we_n_i)
  begin
    // unknown strobes at start-up count as deselected
    if (ce_n_i !== 1'b0 || mode == CHIP)
      step = 3'h0;
    else if (dq_i == FES_DAT_SUSPEND && (mode == WIN || mode == ERS))
    begin
      if (mode == WIN)
        tmr = ERASE_US;
      mode = SUSP;
    end
    else if (dq_i == FES_DAT_BLOCK && mode == SUSP)
      mode = ERS;
    else if (dq_i == FES_DAT_BLOCK && mode == WIN)
    begin
      sel[addr_i[18:15]] = 1'b1;
      tmr = FES_WIN_US;
    end
    else if (dq_i == FES_DAT_RESET && (mode == RD || mode == ERR))
      mode = RD;
    else if (mode == RD && step == 3'h5 && (dq_i == FES_DAT_BLOCK || dq_i == FES_DAT_CHIP && addr_i[10:0] == ua))
    begin
      step = 3'h0;
      sel = {16{dq_i == FES_DAT_CHIP}};
      sel[addr_i[18:15]] = 1'b1;
      mode = (sel == 16'hffff) ? CHIP : WIN;
      tmr = (mode == CHIP) ? ERASE_US : FES_WIN_US;
    end
    else if (mode == RD)
      step = (addr_i[10:0] == ua && dq_i == ud) ? step + 3'h1 : 3'h0;
  end
  // ******
  // microsecond tick for window and erase
  // ******
  always #1000
    if (mode inside {CHIP, WIN, ERS})
    begin
      if (tmr > 1)
        tmr--;
      else if (mode == WIN)
      begin
        mode = ERS;
        tmr = ERASE_US;
      end
      else
        mode = (fail_i && |(sel & ~PROT)) ? ERR : RD;
    end
  // toggles advance as each status read ends, toggle_bit not while suspended, alt_toggle_bit only for selected blocks
  always @(posedge oe_n_i)
  begin
    if (stat && mode != SUSP)
      tog = ~tog;
    if (stat && in_sel)
      alt = ~alt;
  end
endmodule // fes_flash_model
`default_nettype wire

// file: test_flash_erase_suspend_status.sv
`default_nettype none
module test_flash_erase_suspend_status
  import fes_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ER_US = 40; // shortened erase time
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        cmd_valid_i = 1'b0;
  fes_op_t     cmd_op_i = FES_OP_STATUS;
  logic [18:0] cmd_addr_i = 19'h0;
  logic        cmd_ready_o, done_o, busy_o, fail_o, fl_dq_oe_o, fl_ce_n_o, fl_oe_n_o, fl_we_n_o, rb;
  logic [7:0]  status_o, fl_dq_o, dev_dq;
  logic [18:0] fl_addr_o, a;
  logic        fail_inj = 1'b0;
  wire  [7:0]  dq = fl_dq_oe_o ? fl_dq_o : dev_dq; // shared data wire
  logic [4:0]  notes[$];  // busy cared, poll, error, timer, busy
  logic [4:0]  nt;
  fes_op_t     cur = FES_OP_STATUS; // op in flight
  int          n_fail = 0;
  int          samples_checked = 0;
  int          seed = 32'h11c8;
  int          i;
  always #10 clk_i = ~clk_i;
  fes_host dut (.clk_i, .resetn_i, .ce_i(1'b1), .cmd_valid_i, .cmd_op_i, .cmd_addr_i, .cmd_ready_o, .done_o,
    .status_o, .busy_o, .fail_o, .fl_addr_o, .fl_dq_i(dq), .fl_dq_o, .fl_dq_oe_o, .fl_ce_n_o, .fl_oe_n_o,
    .fl_we_n_o, .ready_busy_out_i(rb));
  fes_flash_model #(.ERASE_US(ER_US)) dev (.addr_i(fl_addr_o), .dq_i(dq), .dq_o(dev_dq), .ce_n_i(fl_ce_n_o),
    .oe_n_i(fl_oe_n_o), .we_n_i(fl_we_n_o), .rb_o(rb), .fail_i(fail_inj));
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    n_fail += notes.size();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // one command, bounded waits for take and done
  task automatic cmd(input fes_op_t op, input logic [18:0] ad);
    int k;
    k = 0;
    cmd_op_i <= op;
    cmd_addr_i <= ad;
    cmd_valid_i <= 1'b1;
    do @(posedge clk_i); while (cmd_ready_o !== 1'b1 && ++k < 999);
    cmd_valid_i <= 1'b0;
    cur = op;
    do @(posedge clk_i); while (done_o !== 1'b1 && ++k < 999);
    if (k >= 999)
    begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  // two status reads; busy is only defined on the second
  task automatic st(input logic [18:0] ad, input logic [2:0] e, input logic b);
    notes.push_back({1'b0, e, 1'b0});
    cmd(FES_OP_STATUS, ad);
    notes.push_back({1'b1, e, b});
    cmd(FES_OP_STATUS, ad);
  endtask
  task automatic wait_us(input int n);
    repeat (n * 50) @(posedge clk_i);
  endtask
  // ****** result watcher ******
  always @(posedge clk_i)
    if (done_o === 1'b1 && cur == FES_OP_STATUS && notes.size() > 0)
    begin
      nt = notes.pop_front();
      chk({status_o[7], status_o[5], status_o[3], busy_o & nt[4]}, nt[3:0]);
    end
  initial
  begin
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    a = 19'($random(seed));
    a[18] = 1'b0;
    cmd(FES_OP_CHIP, a);
    st(a, 3'b001, 1'b1);
    cmd(FES_OP_SUSPEND, a);
    st(a, 3'b001, 1'b1);
    wait_us(ER_US);
    st(a, 3'b111, 1'b0);
    $display("chip erase test done");
    cmd(FES_OP_BLOCK, a);
    st(a, 3'b000, 1'b1);
    wait_us(30);
    cmd(FES_OP_ADD, a ^ 19'h20000);
    wait_us(30);
    st(a, 3'b000, 1'b1);
    wait_us(25);
    st(a ^ 19'h20000, 3'b001, 1'b1);
    for (i = 0; i < 2; i++)
    begin
      cmd(FES_OP_SUSPEND, a);
      wait_us(FES_SUSP_US);
      st(a, 3'b101, 1'b0);
      st(a ^ 19'h40000, 3'b111, 1'b0);
      cmd(FES_OP_RESUME, a);
      st(a, 3'b001, 1'b1);
    end
    wait_us(ER_US);
    st(a, 3'b111, 1'b0);
    $display("block erase test done");
    cmd(FES_OP_BLOCK, a);
    cmd(FES_OP_SUSPEND, a);
    st(a, 3'b101, 1'b0);
    cmd(FES_OP_RESUME, a);
    st(a, 3'b001, 1'b1);
    wait_us(ER_US);
    st(a, 3'b111, 1'b0);
    $display("window suspend test done");
    fail_inj <= 1'b1;
    cmd(FES_OP_CHIP, a);
    wait_us(ER_US);
    st(a, 3'b011, 1'b1);
    chk({3'h0, fail_o}, 4'h1);
    cmd(FES_OP_CHIP, a);
    st(a, 3'b011, 1'b1);
    cmd(FES_OP_RESET, a);
    st(a, 3'b111, 1'b0);
    $display("error test done");
    // let the watcher take the last note before counting
    @(posedge clk_i);
    tally_and_finish();
  end
endmodule // test_flash_erase_suspend_status
`default_nettype wire
